// ---- logic/sas_pkg.sv ----
// Package with register map, field layouts and timing constants of the converter sequencer.
`default_nettype none
package sas_pkg;

   // ==========================================================================
   // Register indices (byte address is four times the index)
   // ==========================================================================
   localparam logic [7:0] RESULT_IDX   = 8'h0a;
   localparam logic [7:0] CSR_IDX      = 8'h0b;
   localparam logic [7:0] IRQ_STAT_IDX = 8'h0c;
   localparam logic [7:0] IRQ_MASK_IDX = 8'h0d;

   // ==========================================================================
   // Reset values and codes
   // ==========================================================================
   localparam logic [7:0] RESULT_RESET = 8'h00;
   localparam logic [7:0] CSR_RESET    = 8'h00;
   localparam logic [7:0] FULL_SCALE   = 8'hff;
   localparam logic [7:0] ZERO_SCALE   = 8'h00;
   localparam logic [7:0] TRIAL_FIRST  = 8'h80;
   localparam logic [1:0] IRQ_RESET    = 2'h0;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;

   // ==========================================================================
   // Timing: converter clock is the bus clock divided by four
   // ==========================================================================
   localparam int         ADC_DIV       = 4;
   localparam int         CONV_CLKS     = 12;
   localparam int         APPROX_STEPS  = 8;
   localparam int         LOAD_CLKS     = CONV_CLKS - APPROX_STEPS;
   localparam logic [1:0] DIV_LAST      = 2'(ADC_DIV - 1);
   localparam logic [2:0] LOAD_LAST     = 3'(LOAD_CLKS - 1);
   localparam logic [2:0] BIT_FIRST     = 3'(APPROX_STEPS - 1);
   localparam logic [5:0] CONV_CYC_LAST = 6'(ADC_DIV * CONV_CLKS - 1);

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic [1:0] {S_IDLE, S_LOAD, S_APPROX} sas_state_t;

   typedef struct packed {
      logic       done;
      logic       rsv6;
      logic       power_on;
      logic       rsv4;
      logic [3:0] input_select;
   } sas_csr_t;

   typedef struct packed {
      logic abort;
      logic done;
   } sas_irq_t;

   typedef struct packed {
      logic       power_on;
      logic       sample_load;
      logic [3:0] input_select;
      logic [7:0] trial_code;
   } sas_analog_t;

endpackage
`default_nettype wire

// ---- logic/sas_sequencer.sv ----
// Successive-approximation converter sequencer with an AXI4-Lite register slave.
//
// Behaviour
// - Input above high reference gives FFh, no overflow.
// - Input below low reference gives 00h.
// - Load sample, then eight steps disconnected.
// - Repeat load and steps while converter on.
// - Twelve converter clocks; converter clock is quarter rate.
// - Four-bit select picks input by binary code.
// - Setting power bit starts continuous conversions.
// - Completion sets top status bit; interrupt only if unmasked.
// - Result holds until next conversion completes.
// - Control write while on aborts and restarts.
// - Result read or control write clears flag.
// - Clearing power bit stops conversions.
// - CPU wait mode leaves converter running.
// - Both registers reset to zero.
// - Result is read-only, full 8-bit range.
`timescale 1ns/10ps
`default_nettype none
module sas_sequencer
   import sas_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic              aclk,
   input  wire logic              aresetn,
   input  wire logic              clk_en,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   input  wire logic              comp_above,
   output sas_analog_t            analog_ctrl,
   output logic                   irq
);

   // ==========================================================================
   // Declarations
   // ==========================================================================
   sas_state_t        state;
   sas_state_t        next_state;
   sas_csr_t          control_status_reg;
   sas_irq_t          irq_status;
   sas_irq_t          irq_mask;
   logic [7:0]        result;
   logic [7:0]        sar;
   logic [7:0]        next_sar;
   logic [7:0]        sar_decided;
   logic [2:0]        step_cnt;
   logic [2:0]        next_step_cnt;
   logic [1:0]        div_cnt;
   logic              tick;
   logic              comp_meta;
   logic              comp_sync;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic              aw_held;
   logic              w_held;
   logic              wr_do;
   logic [7:0]        wr_idx;
   logic [7:0]        rd_idx;
   logic              rd_take;
   logic              csr_wr;
   logic              restart;
   logic              result_rd;
   logic              done_evt;
   logic [5:0]        conv_cyc;
   logic              all_high;
   logic              all_low;

   // ==========================================================================
   // Comparator synchroniser
   // ==========================================================================
   // The comparator output is analog-side and asynchronous to the bus clock.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         comp_meta <= 1'b0;
         comp_sync <= 1'b0;
      end else if (clk_en) begin
         comp_meta <= comp_above;
         comp_sync <= comp_meta;
      end
   end

   // ==========================================================================
   // Bus slave: write path
   // ==========================================================================
   assign wr_do   = aw_held && w_held && !s_axi_bvalid;
   assign wr_idx  = aw_addr[9:2];
   assign csr_wr  = clk_en && wr_do && (wr_idx == CSR_IDX) && w_strb[0];
   assign restart = csr_wr && w_data[5];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= '0;
         w_data        <= '0;
         w_strb        <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else if (clk_en) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            aw_addr       <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_do) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (wr_idx == CSR_IDX || wr_idx == IRQ_STAT_IDX || wr_idx == IRQ_MASK_IDX) begin
               s_axi_bresp <= RESP_OKAY;
            end else begin
               s_axi_bresp <= RESP_SLVERR;
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Bus slave: read path
   // ==========================================================================
   assign rd_idx    = s_axi_araddr[9:2];
   assign rd_take   = clk_en && s_axi_arvalid && s_axi_arready;
   assign result_rd = rd_take && (rd_idx == RESULT_IDX);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end else if (clk_en) begin
         if (rd_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= RESP_OKAY;
            case (rd_idx)
               RESULT_IDX:   s_axi_rdata <= {24'h00_0000, result};
               CSR_IDX:      s_axi_rdata <= {24'h00_0000, control_status_reg.done, 1'b0, control_status_reg.power_on, 1'b0,
                                             control_status_reg.input_select};
               IRQ_STAT_IDX: s_axi_rdata <= {30'h0000_0000, irq_status};
               IRQ_MASK_IDX: s_axi_rdata <= {30'h0000_0000, irq_mask};
               default: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

   // ==========================================================================
   // Control/status register
   // ==========================================================================
   // Reserved bits are not stored, so they read as zero whatever is written.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         control_status_reg <= sas_csr_t'(CSR_RESET);
      end else if (clk_en) begin
         if (csr_wr) begin
            control_status_reg.power_on     <= w_data[5];
            control_status_reg.input_select <= w_data[3:0];
         end
         if (done_evt) begin
            control_status_reg.done <= 1'b1;
         end else if (csr_wr || result_rd) begin
            control_status_reg.done <= 1'b0;
         end
      end
   end

   // ==========================================================================
   // Converter clock divider
   // ==========================================================================
   assign tick = clk_en && (div_cnt == DIV_LAST);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_cnt <= '0;
      end else if (clk_en) begin
         if (restart || state == S_IDLE) begin
            div_cnt <= '0;
         end else begin
            div_cnt <= div_cnt + 2'h1;
         end
      end
   end

   // ==========================================================================
   // Sequencer
   // ==========================================================================
   // The sequencer has no wait-mode input: the CPU sleeping does not touch it.
   assign sar_decided = comp_sync ? sar : (sar & ~(8'h01 << step_cnt));
   assign done_evt    = tick && (state == S_APPROX) && (step_cnt == 3'h0) && !csr_wr;

   always_comb begin
      next_state    = state;
      next_step_cnt = step_cnt;
      next_sar      = sar;
      case (state)
         S_IDLE: begin
            next_sar = '0;
         end
         S_LOAD: begin
            if (tick) begin
               if (step_cnt == LOAD_LAST) begin
                  next_state    = S_APPROX;
                  next_step_cnt = BIT_FIRST;
                  next_sar      = TRIAL_FIRST;
               end else begin
                  next_step_cnt = step_cnt + 3'h1;
               end
            end
         end
         S_APPROX: begin
            if (tick) begin
               if (step_cnt == 3'h0) begin
                  next_state    = S_LOAD;
                  next_step_cnt = '0;
                  next_sar      = '0;
               end else begin
                  next_step_cnt = step_cnt - 3'h1;
                  next_sar      = sar_decided | (8'h01 << (step_cnt - 3'h1));
               end
            end
         end
         default: begin
            next_state = S_IDLE;
         end
      endcase
      if (csr_wr) begin
         next_step_cnt = '0;
         next_sar      = '0;
         next_state    = w_data[5] ? S_LOAD : S_IDLE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state    <= S_IDLE;
         step_cnt <= '0;
         sar      <= '0;
      end else if (clk_en) begin
         state    <= next_state;
         step_cnt <= next_step_cnt;
         sar      <= next_sar;
      end
   end

   // Only a finished conversion touches the result; an aborted one is dropped.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result <= RESULT_RESET;
      end else if (done_evt) begin
         result <= sar_decided;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         analog_ctrl <= '0;
      end else if (clk_en) begin
         analog_ctrl.power_on     <= (next_state != S_IDLE);
         analog_ctrl.sample_load  <= (next_state == S_LOAD);
         analog_ctrl.input_select <= csr_wr ? w_data[3:0] : control_status_reg.input_select;
         analog_ctrl.trial_code   <= next_sar;
      end
   end

   // ==========================================================================
   // Interrupt status and mask
   // ==========================================================================
   // The mask resets to zero, so completion raises no interrupt unless enabled.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_status <= IRQ_RESET;
         irq_mask   <= IRQ_RESET;
         irq        <= 1'b0;
      end else if (clk_en) begin
         if (wr_do && wr_idx == IRQ_MASK_IDX && w_strb[0]) begin
            irq_mask <= w_data[1:0];
         end
         if (wr_do && wr_idx == IRQ_STAT_IDX && w_strb[0]) begin
            irq_status <= (irq_status & ~w_data[1:0]) | {restart, done_evt};
         end else begin
            irq_status <= irq_status | {restart, done_evt};
         end
         irq <= |(irq_status & irq_mask);
      end
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conv_cyc <= '0;
         all_high <= 1'b1;
         all_low  <= 1'b1;
      end else if (clk_en) begin
         if (restart || done_evt) begin
            conv_cyc <= '0;
            all_high <= 1'b1;
            all_low  <= 1'b1;
         end else if (state != S_IDLE) begin
            conv_cyc <= conv_cyc + 6'h01;
            if (tick && state == S_APPROX) begin
               all_high <= all_high && comp_sync;
               all_low  <= all_low && !comp_sync;
            end
         end
      end
   end

   sequence load_phase_s;
      state == S_LOAD;
   endsequence

   sequence approx_start_s;
      state == S_APPROX && step_cnt == BIT_FIRST && sar == TRIAL_FIRST;
   endsequence

   full_scale_a: assert property (done_evt && all_high && comp_sync |=> result == FULL_SCALE)
      else $error("full-scale input did not give all ones");
   zero_scale_a: assert property (done_evt && all_low && !comp_sync |=> result == ZERO_SCALE)
      else $error("zero input did not give all zeros");
   load_then_approx_a: assert property ($rose(state == S_APPROX) |-> $past(state) == S_LOAD)
      else $error("approximation began without a load phase");
   phase_order_a: assert property (load_phase_s ##1 approx_start_s |-> !analog_ctrl.sample_load)
      else $error("sample switch closed during approximation");
   back_to_back_a: assert property (done_evt && control_status_reg.power_on |=> load_phase_s)
      else $error("conversion did not restart after completion");
   conv_length_a: assert property (done_evt |-> conv_cyc == CONV_CYC_LAST)
      else $error("conversion length is not twelve converter clocks");
   tick_spacing_a: assert property ($past(clk_en, 3) && $past(clk_en, 2) && $past(clk_en)
                                    && tick && !restart |-> $past(div_cnt, 3) == 2'h0)
      else $error("converter tick not every fourth cycle");
   select_follow_a: assert property (clk_en |=> analog_ctrl.input_select == control_status_reg.input_select)
      else $error("input select does not follow its field");
   flag_set_a: assert property (done_evt |=> control_status_reg.done && result == $past(sar_decided))
      else $error("completion flag not set at conversion end");
   no_irq_a: assert property ($past(irq_mask) == IRQ_RESET |-> !irq)
      else $error("interrupt raised while masked");
   result_hold_a: assert property (!$stable(result) |-> $past(done_evt))
      else $error("result changed without a finished conversion");
   abort_restart_a: assert property (restart |=> load_phase_s and (step_cnt == 3'h0 && !control_status_reg.done))
      else $error("control write did not restart the conversion");
   flag_clear_a: assert property ((result_rd || csr_wr) && !done_evt |=> !control_status_reg.done)
      else $error("completion flag not cleared");
   power_off_a: assert property (!control_status_reg.power_on |-> state == S_IDLE)
      else $error("converter running while switched off");

endmodule
`default_nettype wire

// ---- tb/sas_analog_model.sv ----
// Behavioural model of the sample capacitor and comparator behind the sequencer.
`timescale 1ns/10ps
`default_nettype none
module sas_analog_model
   import sas_pkg::*;
(
   input  wire logic         aclk,
   input  wire sas_analog_t  ctrl,
   input  wire logic [127:0] levels,
   input  wire logic         slow,
   output logic              comp_above
);
   logic [7:0] held   = 8'h00;
   logic       slow_q = 1'b0;
   logic       idle_q = 1'b0;

   // ==========================================================================
   // Capacitor
   // ==========================================================================
   // The capacitor follows the input only while connected and keeps its charge after.
   always @(posedge aclk) begin
      if (ctrl.power_on && ctrl.sample_load) begin
         held <= levels[{ctrl.input_select, 3'b000} +: 8];
      end
   end

   // ==========================================================================
   // Comparator
   // ==========================================================================
   always @(posedge aclk) begin
      slow_q <= (held >= ctrl.trial_code);
      idle_q <= ~idle_q;
   end

   // An unpowered comparator has no meaningful answer, so it toggles every cycle.
   assign comp_above = !ctrl.power_on ? idle_q :
                       slow ? slow_q : (held >= ctrl.trial_code);
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking testbench of the converter sequencer.
`timescale 1ns/10ps
`default_nettype none
module tb;
   import sas_pkg::*;
   logic         aclk = 1'b0;
   logic         aresetn;
   logic [11:0]  s_axi_awaddr, s_axi_araddr;
   logic         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [31:0]  s_axi_wdata, s_axi_rdata;
   logic [1:0]   s_axi_bresp, s_axi_rresp;
   logic         comp_above, irq, slow, clk_en;
   logic [127:0] levels;
   sas_analog_t  analog_ctrl;
   int           n_mismatch = 0;
   int           comparisons = 0;

   always #25 aclk = ~aclk;

   sas_sequencer #(.ADDR_W(12)) dut (.aclk, .aresetn, .clk_en, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .comp_above, .analog_ctrl, .irq);

   sas_analog_model model (.aclk, .ctrl(analog_ctrl), .levels, .slow, .comp_above);

   // ==========================================================================
   // Helpers
   // ==========================================================================
   task automatic stop_test();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      int t;
      t = 0;
      s_axi_awaddr  <= {2'b00, idx, 2'b00};
      s_axi_wdata   <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && t < 100);
      chk("write response", {29'h0, 1'b1, er}, {29'h0, s_axi_bvalid, s_axi_bresp});
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er,
                     input string what);
      int t;
      t = 0;
      s_axi_araddr  <= {2'b00, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         t++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && t < 100);
      chk("read response", {29'h0, 1'b1, er}, {29'h0, s_axi_rvalid, s_axi_rresp});
      if (er === RESP_OKAY) chk(what, exp, s_axi_rdata);
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask

   // Ends at the falling edge where a new sample-load phase is first seen.
   task automatic wait_load();
      int t;
      t = 0;
      do begin
         @(negedge aclk);
         t++;
      end while (analog_ctrl.sample_load !== 1'b0 && t < 200);
      do begin
         @(negedge aclk);
         t++;
      end while (analog_ctrl.sample_load !== 1'b1 && t < 200);
   endtask

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic t_reset();
      chk("analog control", 32'h0, analog_ctrl);
      chk("irq", 32'h0, irq);
      rd(RESULT_IDX, 32'h0, RESP_OKAY, "result");
      rd(CSR_IDX, 32'h0, RESP_OKAY, "status");
      rd(IRQ_STAT_IDX, 32'h0, RESP_OKAY, "irq status");
      rd(IRQ_MASK_IDX, 32'h0, RESP_OKAY, "irq mask");
   endtask

   task automatic t_access();
      wr(RESULT_IDX, 8'h55, RESP_SLVERR);
      rd(RESULT_IDX, 32'h0, RESP_OKAY, "result");
      rd(8'h0f, 32'h0, RESP_SLVERR, "unmapped");
   endtask

   task automatic t_channels();
      for (int ch = 0; ch < 16; ch++) begin
         slow <= ch[0];
         wr(CSR_IDX, 8'h20 | 8'(ch), RESP_OKAY);
         repeat (60) @(posedge aclk);
         rd(CSR_IDX, 32'h0000_00a0 | 32'(ch), RESP_OKAY, "status");
         rd(RESULT_IDX, 32'(ch * 17), RESP_OKAY, "result");
         rd(CSR_IDX, 32'h0000_0020 | 32'(ch), RESP_OKAY, "status");
         chk("irq", 32'h0, irq);
      end
   endtask

   task automatic t_timing();
      int         hi;
      int         lo;
      int         chg;
      logic [7:0] prev;
      hi = 0;
      lo = 0;
      chg = 0;
      wait_load();
      do begin
         hi++;
         @(negedge aclk);
      end while (analog_ctrl.sample_load === 1'b1 && hi < 100);
      chk("first trial", 32'(TRIAL_FIRST), 32'(analog_ctrl.trial_code));
      prev = analog_ctrl.trial_code;
      do begin
         lo++;
         @(negedge aclk);
         if (analog_ctrl.sample_load === 1'b0 && analog_ctrl.trial_code !== prev) chg++;
         prev = analog_ctrl.trial_code;
      end while (analog_ctrl.sample_load === 1'b0 && lo < 100);
      chk("load cycles", 32'(LOAD_CLKS * ADC_DIV), 32'(hi));
      chk("approx cycles", 32'(APPROX_STEPS * ADC_DIV), 32'(lo));
      chk("trial steps", 32'(APPROX_STEPS - 1), 32'(chg));
      @(posedge aclk);
   endtask

   task automatic t_hold();
      wr(CSR_IDX, 8'h23, RESP_OKAY);
      wait_load();
      @(posedge aclk);
      rd(RESULT_IDX, 32'h33, RESP_OKAY, "result");
      levels[24 +: 8] <= 8'hc4;
      // A frozen clock enable must stretch the conversion, so the old result still stands.
      clk_en <= 1'b0;
      repeat (100) @(posedge aclk);
      clk_en <= 1'b1;
      repeat (20) @(posedge aclk);
      rd(RESULT_IDX, 32'h33, RESP_OKAY, "result held");
      repeat (100) @(posedge aclk);
      rd(RESULT_IDX, 32'hc4, RESP_OKAY, "result updated");
   endtask

   task automatic t_abort();
      for (int i = 0; i < 4; i++) begin
         wr(CSR_IDX, 8'h23, RESP_OKAY);
         levels[24 +: 8] <= 8'h5e;
         repeat (20) @(posedge aclk);
      end
      rd(CSR_IDX, 32'h23, RESP_OKAY, "status after abort");
      rd(RESULT_IDX, 32'hc4, RESP_OKAY, "result after abort");
      repeat (60) @(posedge aclk);
      rd(RESULT_IDX, 32'h5e, RESP_OKAY, "result after restart");
   endtask

   task automatic t_irq();
      int on;
      on = 0;
      rd(IRQ_STAT_IDX, 32'h3, RESP_OKAY, "irq status");
      chk("irq", 32'h0, irq);
      wr(CSR_IDX, 8'h00, RESP_OKAY);
      wr(IRQ_STAT_IDX, 8'h03, RESP_OKAY);
      rd(IRQ_STAT_IDX, 32'h0, RESP_OKAY, "irq status cleared");
      wr(IRQ_MASK_IDX, 8'h03, RESP_OKAY);
      repeat (100) begin
         @(negedge aclk);
         if (analog_ctrl.power_on !== 1'b0 || analog_ctrl.sample_load !== 1'b0) on++;
         if (irq !== 1'b0) on++;
      end
      @(posedge aclk);
      chk("activity while off", 32'h0, 32'(on));
      rd(CSR_IDX, 32'h0, RESP_OKAY, "status while off");
      wr(CSR_IDX, 8'h22, RESP_OKAY);
      repeat (60) @(posedge aclk);
      chk("irq unmasked", 32'h1, irq);
      wr(CSR_IDX, 8'h00, RESP_OKAY);
      wr(IRQ_STAT_IDX, 8'h03, RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk("irq cleared", 32'h0, irq);
      wr(IRQ_MASK_IDX, 8'h00, RESP_OKAY);
   endtask

   // ==========================================================================
   // Main sequence and watchdog
   // ==========================================================================
   initial begin
      aresetn = 1'b0;
      s_axi_awaddr = 12'h000;
      s_axi_araddr = 12'h000;
      s_axi_wdata = 32'h0000_0000;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      slow = 1'b0;
      clk_en = 1'b1;
      for (int i = 0; i < 16; i++) levels[i * 8 +: 8] = 8'(i * 17);
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_access();
      t_channels();
      t_timing();
      t_hold();
      t_abort();
      t_irq();
      stop_test();
   end

   // The whole run needs about 2000 cycles, so this span only trips on a hang.
   initial begin
      #(20000 * 50);
      n_mismatch++;
      stop_test();
   end
endmodule
`default_nettype wire
